// File: verilog/wiper_params.svh
`ifndef WIPER_PARAMS_SVH
`define WIPER_PARAMS_SVH

`define TAP_COUNT 64
`define POS_W 6
`define NUM_POTS 2
`define NUM_SLOTS 4
`define SLOT_W 2
`define POT_W 1
`define DATA_W 8
`define OP_W 4
`define POS_MAX 6'h3f
`define POS_MIN 6'h00
`define POS_RESET 6'h20
`define AMP_RESET 8'h00
`define POWERUP_SLOT 2'h0
`define CLK_PERIOD_NS 10
`define NV_WRITE_TIME_NS 10000
`define NV_WRITE_CYCLES ((`NV_WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NV_CNT_W 10
`define STEP_HOLD_CYCLES 2
`define HOLD_CNT_W 2

`endif

// File: verilog/wiper_pkg.sv
`include "wiper_params.svh"
`default_nettype none
package wiper_pkg;
    typedef logic [`POS_W-1:0] pos_t;
    typedef logic [`DATA_W-1:0] data_t;

    typedef enum logic [`OP_W-1:0] {
        OP_READ_WIPER = 4'h0,
        OP_WRITE_WIPER = 4'h1,
        OP_READ_STORED = 4'h2,
        OP_WRITE_STORED = 4'h3,
        OP_STORED_TO_WIPER = 4'h4,
        OP_WIPER_TO_STORED = 4'h5,
        OP_GLOBAL_TO_WIPER = 4'h6,
        OP_GLOBAL_TO_STORED = 4'h7,
        OP_STEP_WIPER = 4'h8,
        OP_READ_BUSY = 4'h9,
        OP_WRITE_AMP = 4'ha,
        OP_READ_AMP = 4'hb
    } opcode_t;

    typedef enum logic [2:0] {
        ST_RESTORE = 3'h1,
        ST_READY = 3'h2,
        ST_NV_WRITE = 3'h4
    } dev_state_t;

    typedef enum logic [3:0] {
        HS_IDLE = 4'h1,
        HS_HIGH = 4'h2,
        HS_LOW = 4'h4,
        HS_RELEASE = 4'h8
    } host_state_t;
endpackage
`default_nettype wire

// File: verilog/wiper_link_if.sv
`include "wiper_params.svh"
`default_nettype none
interface wiper_link_if;
    import wiper_pkg::*;
    logic cs_n;
    logic step;
    logic dir;
    logic cmd_valid;
    logic cmd_ready;
    opcode_t cmd_op;
    logic [`POT_W-1:0] cmd_pot;
    logic [`SLOT_W-1:0] cmd_slot;
    data_t cmd_data;
    logic rsp_valid;
    data_t rsp_data;

    modport host (
        output cs_n, step, dir, cmd_valid, cmd_op, cmd_pot, cmd_slot, cmd_data,
        input cmd_ready, rsp_valid, rsp_data
    );
    modport device (
        input cs_n, step, dir, cmd_valid, cmd_op, cmd_pot, cmd_slot, cmd_data,
        output cmd_ready, rsp_valid, rsp_data
    );
endinterface
`default_nettype wire

// File: verilog/tap_decoder.sv
`include "wiper_params.svh"
`default_nettype none
module tap_decoder
    import wiper_pkg::*;
(
    input wire pos_t pos_i,
    output logic [`TAP_COUNT-1:0] tap_sel_o
);
    always_comb
    begin
        tap_sel_o = '0;
        tap_sel_o[pos_i] = 1'b1;
    end
endmodule // tap_decoder
`default_nettype wire

// File: verilog/wiper_device.sv
`include "wiper_params.svh"
`default_nettype none
module wiper_device
    import wiper_pkg::*;
#(
    parameter int NV_WRITE_CYCLES = `NV_WRITE_CYCLES
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    wiper_link_if.device bus,
    output logic [`NUM_POTS-1:0][`TAP_COUNT-1:0] tap_sel_o,
    output logic [`NUM_POTS-1:0][`POS_W-1:0] wiper_pos_o,
    output logic [`DATA_W-1:0] amp_ctrl_o,
    output logic nv_write_busy_o
);
    localparam logic [`NV_CNT_W-1:0] NV_LAST = `NV_CNT_W'(NV_WRITE_CYCLES - 1);

    dev_state_t state_reg;
    dev_state_t state_next;
    logic [`NV_CNT_W-1:0] cnt_reg;
    logic [`NV_CNT_W-1:0] cnt_next;
    pos_t wiper_reg [`NUM_POTS];
    pos_t wiper_next [`NUM_POTS];
    pos_t stored_reg [`NUM_POTS][`NUM_SLOTS];
    pos_t stored_next [`NUM_POTS][`NUM_SLOTS];
    data_t amp_reg;
    data_t amp_next;
    logic step_prev_reg;
    logic step_prev_next;
    logic rsp_valid_reg;
    logic rsp_valid_next;
    data_t rsp_data_reg;
    data_t rsp_data_next;
    logic busy;
    logic cmd_fire;
    logic step_fall;

    function automatic pos_t step_pos(input pos_t pos, input logic up);
        if (up)
        begin
            step_pos = (pos == `POS_MAX) ? pos : pos + 1'b1;
        end
        else
        begin
            step_pos = (pos == `POS_MIN) ? pos : pos - 1'b1;
        end
    endfunction

    function automatic data_t to_data(input pos_t pos);
        to_data = {{(`DATA_W - `POS_W){1'b0}}, pos};
    endfunction

    function automatic logic writes_nv(input opcode_t op);
        writes_nv = (op == OP_WRITE_STORED) || (op == OP_WIPER_TO_STORED) ||
                    (op == OP_GLOBAL_TO_STORED);
    endfunction

    assign busy = (state_reg == ST_NV_WRITE);
    assign nv_write_busy_o = busy;
    // nv writes wait for the previous one; everything else is taken, except during restore when nothing is
    assign bus.cmd_ready = (state_reg != ST_RESTORE) && !(busy && writes_nv(bus.cmd_op));
    assign cmd_fire = bus.cmd_valid && bus.cmd_ready;
    assign bus.rsp_valid = rsp_valid_reg;
    assign bus.rsp_data = rsp_data_reg;
    assign amp_ctrl_o = amp_reg;
    assign step_fall = !bus.cs_n && step_prev_reg && !bus.step;

    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        wiper_next = wiper_reg;
        stored_next = stored_reg;
        amp_next = amp_reg;
        step_prev_next = bus.step;
        rsp_valid_next = 1'b0;
        rsp_data_next = rsp_data_reg;
        case (state_reg)
            ST_RESTORE:
            begin
                for (int p = 0; p < `NUM_POTS; p++)
                begin
                    wiper_next[p] = stored_reg[p][`POWERUP_SLOT];
                end
                state_next = ST_READY;
            end
            ST_READY, ST_NV_WRITE:
            begin
                if (state_reg == ST_NV_WRITE)
                begin
                    if (cnt_reg == '0)
                    begin
                        state_next = ST_READY;
                    end
                    else
                    begin
                        cnt_next = cnt_reg - 1'b1;
                    end
                end
                if (step_fall)
                begin
                    wiper_next[0] = step_pos(wiper_reg[0], bus.dir);
                end
                if (cmd_fire)
                begin
                    rsp_valid_next = 1'b1;
                    rsp_data_next = '0;
                    case (bus.cmd_op)
                        OP_READ_WIPER:
                        begin
                            rsp_data_next = to_data(wiper_reg[bus.cmd_pot]);
                        end
                        OP_WRITE_WIPER:
                        begin
                            wiper_next[bus.cmd_pot] = bus.cmd_data[`POS_W-1:0];
                        end
                        OP_READ_STORED:
                        begin
                            rsp_data_next = to_data(stored_reg[bus.cmd_pot][bus.cmd_slot]);
                        end
                        OP_WRITE_STORED:
                        begin
                            stored_next[bus.cmd_pot][bus.cmd_slot] = bus.cmd_data[`POS_W-1:0];
                            state_next = ST_NV_WRITE;
                            cnt_next = NV_LAST;
                        end
                        OP_STORED_TO_WIPER:
                        begin
                            wiper_next[bus.cmd_pot] = stored_reg[bus.cmd_pot][bus.cmd_slot];
                        end
                        OP_WIPER_TO_STORED:
                        begin
                            stored_next[bus.cmd_pot][bus.cmd_slot] = wiper_reg[bus.cmd_pot];
                            state_next = ST_NV_WRITE;
                            cnt_next = NV_LAST;
                        end
                        OP_GLOBAL_TO_WIPER:
                        begin
                            for (int p = 0; p < `NUM_POTS; p++)
                            begin
                                wiper_next[p] = stored_reg[p][bus.cmd_slot];
                            end
                        end
                        OP_GLOBAL_TO_STORED:
                        begin
                            for (int p = 0; p < `NUM_POTS; p++)
                            begin
                                stored_next[p][bus.cmd_slot] = wiper_reg[p];
                            end
                            state_next = ST_NV_WRITE;
                            cnt_next = NV_LAST;
                        end
                        OP_STEP_WIPER:
                        begin
                            wiper_next[bus.cmd_pot] =
                                step_pos(wiper_reg[bus.cmd_pot], bus.cmd_data[0]);
                        end
                        OP_READ_BUSY:
                        begin
                            rsp_data_next = {{(`DATA_W - 1){1'b0}}, busy};
                        end
                        OP_WRITE_AMP:
                        begin
                            amp_next = bus.cmd_data;
                        end
                        OP_READ_AMP:
                        begin
                            rsp_data_next = amp_reg;
                        end
                        default:
                        begin
                            rsp_data_next = '0;
                        end
                    endcase
                end
            end
            default:
            begin
                state_next = ST_RESTORE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_reg <= ST_RESTORE;
            cnt_reg <= '0;
            amp_reg <= `AMP_RESET;
            step_prev_reg <= 1'b0;
            rsp_valid_reg <= 1'b0;
            rsp_data_reg <= '0;
            for (int p = 0; p < `NUM_POTS; p++)
            begin
                wiper_reg[p] <= `POS_RESET;
                for (int s = 0; s < `NUM_SLOTS; s++)
                begin
                    stored_reg[p][s] <= `POS_RESET;
                end
            end
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            amp_reg <= amp_next;
            step_prev_reg <= step_prev_next;
            rsp_valid_reg <= rsp_valid_next;
            rsp_data_reg <= rsp_data_next;
            wiper_reg <= wiper_next;
            stored_reg <= stored_next;
        end
    end

    for (genvar p = 0; p < `NUM_POTS; p++)
    begin : g_pot
        assign wiper_pos_o[p] = wiper_reg[p];
        tap_decoder u_dec (
            .pos_i(wiper_reg[p]),
            .tap_sel_o(tap_sel_o[p])
        );
    end
endmodule // wiper_device
`default_nettype wire

// File: verilog/wiper_host.sv
`include "wiper_params.svh"
`default_nettype none
module wiper_host
    import wiper_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    wiper_link_if.host bus,
    input wire logic user_cmd_valid_i,
    input wire opcode_t user_cmd_op_i,
    input wire logic [`POT_W-1:0] user_cmd_pot_i,
    input wire logic [`SLOT_W-1:0] user_cmd_slot_i,
    input wire logic [`DATA_W-1:0] user_cmd_data_i,
    output logic user_cmd_ready_o,
    output logic user_rsp_valid_o,
    output logic [`DATA_W-1:0] user_rsp_data_o,
    input wire logic user_step_req_i,
    input wire logic user_step_up_i,
    output logic user_step_ready_o
);
    localparam logic [`HOLD_CNT_W-1:0] HOLD_LAST = `HOLD_CNT_W'(`STEP_HOLD_CYCLES - 1);

    host_state_t state_reg;
    host_state_t state_next;
    logic [`HOLD_CNT_W-1:0] hold_reg;
    logic [`HOLD_CNT_W-1:0] hold_next;
    logic dir_reg;
    logic dir_next;
    logic cmd_valid_reg;
    logic cmd_valid_next;
    opcode_t cmd_op_reg;
    opcode_t cmd_op_next;
    logic [`POT_W-1:0] cmd_pot_reg;
    logic [`POT_W-1:0] cmd_pot_next;
    logic [`SLOT_W-1:0] cmd_slot_reg;
    logic [`SLOT_W-1:0] cmd_slot_next;
    data_t cmd_data_reg;
    data_t cmd_data_next;
    logic rsp_valid_reg;
    logic rsp_valid_next;
    data_t rsp_data_reg;
    data_t rsp_data_next;

    assign bus.cs_n = (state_reg == HS_IDLE);
    assign bus.step = (state_reg == HS_HIGH);
    assign bus.dir = dir_reg;
    assign user_step_ready_o = (state_reg == HS_IDLE);
    assign bus.cmd_valid = cmd_valid_reg;
    assign bus.cmd_op = cmd_op_reg;
    assign bus.cmd_pot = cmd_pot_reg;
    assign bus.cmd_slot = cmd_slot_reg;
    assign bus.cmd_data = cmd_data_reg;
    assign user_cmd_ready_o = !cmd_valid_reg;
    assign user_rsp_valid_o = rsp_valid_reg;
    assign user_rsp_data_o = rsp_data_reg;

    always_comb
    begin
        state_next = state_reg;
        hold_next = hold_reg;
        dir_next = dir_reg;
        case (state_reg)
            HS_IDLE:
            begin
                if (user_step_req_i)
                begin
                    dir_next = user_step_up_i;
                    hold_next = HOLD_LAST;
                    state_next = HS_HIGH;
                end
            end
            HS_HIGH, HS_LOW:
            begin
                if (hold_reg == '0)
                begin
                    hold_next = HOLD_LAST;
                    state_next = (state_reg == HS_HIGH) ? HS_LOW : HS_RELEASE;
                end
                else
                begin
                    hold_next = hold_reg - 1'b1;
                end
            end
            HS_RELEASE:
            begin
                state_next = HS_IDLE;
            end
            default:
            begin
                state_next = HS_IDLE;
            end
        endcase
    end

    always_comb
    begin
        cmd_valid_next = cmd_valid_reg;
        cmd_op_next = cmd_op_reg;
        cmd_pot_next = cmd_pot_reg;
        cmd_slot_next = cmd_slot_reg;
        cmd_data_next = cmd_data_reg;
        rsp_valid_next = bus.rsp_valid;
        rsp_data_next = bus.rsp_valid ? bus.rsp_data : rsp_data_reg;
        if (cmd_valid_reg && bus.cmd_ready)
        begin
            cmd_valid_next = 1'b0;
        end
        else if (!cmd_valid_reg && user_cmd_valid_i)
        begin
            cmd_valid_next = 1'b1;
            cmd_op_next = user_cmd_op_i;
            cmd_pot_next = user_cmd_pot_i;
            cmd_slot_next = user_cmd_slot_i;
            cmd_data_next = user_cmd_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_reg <= HS_IDLE;
            hold_reg <= '0;
            dir_reg <= 1'b0;
            cmd_valid_reg <= 1'b0;
            cmd_op_reg <= OP_READ_WIPER;
            cmd_pot_reg <= '0;
            cmd_slot_reg <= '0;
            cmd_data_reg <= '0;
            rsp_valid_reg <= 1'b0;
            rsp_data_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            hold_reg <= hold_next;
            dir_reg <= dir_next;
            cmd_valid_reg <= cmd_valid_next;
            cmd_op_reg <= cmd_op_next;
            cmd_pot_reg <= cmd_pot_next;
            cmd_slot_reg <= cmd_slot_next;
            cmd_data_reg <= cmd_data_next;
            rsp_valid_reg <= rsp_valid_next;
            rsp_data_reg <= rsp_data_next;
        end
    end
endmodule // wiper_host
`default_nettype wire

// File: bench/wiper_link_chk.sv
`include "wiper_params.svh"
`default_nettype none
module wiper_link_chk
    import wiper_pkg::*;
#(
    parameter int NV_WRITE_CYCLES = `NV_WRITE_CYCLES
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cs_n,
    input wire logic step,
    input wire logic dir,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire opcode_t cmd_op,
    input wire data_t cmd_data,
    input wire logic rsp_valid,
    input wire data_t rsp_data
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic take;
    logic nv_req;
    logic [`NV_CNT_W-1:0] nv_cnt_reg;
    logic [`NV_CNT_W-1:0] nv_cnt_next;

    assign take = cmd_valid && cmd_ready;
    assign nv_req = cmd_valid
        && (cmd_op inside {OP_WRITE_STORED, OP_WIPER_TO_STORED, OP_GLOBAL_TO_STORED});

    // cycles of busy left after a stored write
    always_comb
    begin
        nv_cnt_next = nv_cnt_reg;
        if (nv_req && cmd_ready)
            nv_cnt_next = NV_WRITE_CYCLES[`NV_CNT_W-1:0];
        else if (nv_cnt_reg != '0)
            nv_cnt_next = nv_cnt_reg - 1'b1;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            nv_cnt_reg <= '0;
        else
            nv_cnt_reg <= nv_cnt_next;
    end

    sequence s_take;
        cmd_valid && cmd_ready;
    endsequence

    sequence s_step_pulse;
        step [*2] ##1 (!step && !cs_n) [*3] ##1 cs_n;
    endsequence

    property p_rsp_follows;
        s_take |=> rsp_valid;
    endproperty
    property p_rsp_cause;
        rsp_valid |-> $past(take);
    endproperty
    property p_nv_refuse;
        nv_req && nv_cnt_reg != '0 |-> !cmd_ready;
    endproperty
    property p_nv_resume;
        nv_req && nv_cnt_reg == 1 |=> cmd_ready;
    endproperty
    property p_busy_read;
        s_take ##0 cmd_op == OP_READ_BUSY
            |=> rsp_data == (($past(nv_cnt_reg) != '0) ? 8'h01 : 8'h00);
    endproperty
    property p_pos_width;
        s_take ##0 cmd_op inside {OP_READ_WIPER, OP_READ_STORED}
            |=> rsp_data[`DATA_W-1:`POS_W] == '0;
    endproperty
    property p_step_cs;
        step |-> !cs_n;
    endproperty
    property p_step_shape;
        $rose(step) |-> s_step_pulse;
    endproperty
    property p_dir_level;
        !cs_n && !$past(cs_n) |-> $stable(dir);
    endproperty

    a_rsp_follows: assert property (p_rsp_follows) else $error("no response after command");
    a_rsp_cause: assert property (p_rsp_cause) else $error("response without command");
    a_nv_refuse: assert property (p_nv_refuse) else $error("stored write taken while busy");
    a_nv_resume: assert property (p_nv_resume) else $error("stored write not resumed");
    a_busy_read: assert property (p_busy_read) else $error("busy read value wrong");
    a_pos_width: assert property (p_pos_width) else $error("position read too wide");
    a_step_cs: assert property (p_step_cs) else $error("step with chip select off");
    a_step_shape: assert property (p_step_shape) else $error("step pulse shape wrong");
    a_dir_level: assert property (p_dir_level) else $error("direction moved while selected");
endmodule // wiper_link_chk
`default_nettype wire

// File: bench/wiper_position_control_tb.sv
`include "wiper_params.svh"
`default_nettype none
module wiper_position_control_tb
    import wiper_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NV_CYC = 20;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic u_valid = 1'b0;
    opcode_t u_op = OP_READ_WIPER;
    logic [`POT_W-1:0] u_pot = '0;
    logic [`SLOT_W-1:0] u_slot = '0;
    data_t u_data = '0;
    logic s_req = 1'b0;
    logic s_up = 1'b0;
    logic u_ready;
    logic r_valid;
    logic s_ready;
    logic busy;
    data_t r_data;
    data_t rd;
    logic [`DATA_W-1:0] amp;
    logic [`NUM_POTS-1:0][`TAP_COUNT-1:0] taps;
    logic [`NUM_POTS-1:0][`POS_W-1:0] pos;
    logic [`NUM_POTS-1:0][`POS_W-1:0] pos2;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;

    wiper_link_if link ();
    wiper_link_if link2 ();

    always #5 clk_i = ~clk_i;

    wiper_device #(.NV_WRITE_CYCLES(NV_CYC)) wiper_device_inst (.clk_i(clk_i), .rst_i(rst_i),
        .bus(link), .tap_sel_o(taps), .wiper_pos_o(pos), .amp_ctrl_o(amp),
        .nv_write_busy_o(busy));
    // second device driven directly, for pin misuse
    wiper_device #(.NV_WRITE_CYCLES(NV_CYC)) wiper_device_inst2 (.clk_i(clk_i), .rst_i(rst_i),
        .bus(link2), .tap_sel_o(), .wiper_pos_o(pos2), .amp_ctrl_o(), .nv_write_busy_o());
    wiper_host wiper_host_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(link),
        .user_cmd_valid_i(u_valid), .user_cmd_op_i(u_op), .user_cmd_pot_i(u_pot),
        .user_cmd_slot_i(u_slot), .user_cmd_data_i(u_data), .user_cmd_ready_o(u_ready),
        .user_rsp_valid_o(r_valid), .user_rsp_data_o(r_data), .user_step_req_i(s_req),
        .user_step_up_i(s_up), .user_step_ready_o(s_ready));
    wiper_link_chk #(.NV_WRITE_CYCLES(NV_CYC)) wiper_link_chk_inst (.clk_i(clk_i),
        .rst_i(rst_i), .cs_n(link.cs_n), .step(link.step), .dir(link.dir),
        .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready), .cmd_op(link.cmd_op),
        .cmd_data(link.cmd_data), .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data));

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask

    task automatic do_cmd(input opcode_t op, input logic [`POT_W-1:0] pot,
                          input logic [`SLOT_W-1:0] slot, input data_t d, output data_t r);
        // a hang here is caught by the cycle ceiling
        while (u_ready !== 1'b1)
        begin
            tick();
        end
        u_valid = 1'b1;
        u_op = op;
        u_pot = pot;
        u_slot = slot;
        u_data = d;
        tick();
        u_valid = 1'b0;
        while (r_valid !== 1'b1)
        begin
            tick();
        end
        r = r_data;
    endtask

    task automatic do_step(input logic up);
        s_req = 1'b1;
        s_up = up;
        tick();
        s_req = 1'b0;
        tick();
        while (s_ready !== 1'b1)
        begin
            tick();
        end
    endtask

    // pulse the second device's step pin
    task automatic pulse2(input logic csn, input logic up);
        link2.cs_n = csn;
        link2.dir = up;
        tick();
        link2.step = 1'b1;
        repeat (2) tick();
        link2.step = 1'b0;
        repeat (2) tick();
        link2.cs_n = 1'b1;
        tick();
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    initial
    begin
        link2.cs_n = 1'b1;
        link2.step = 1'b0;
        link2.dir = 1'b0;
        link2.cmd_valid = 1'b0;
        link2.cmd_op = OP_READ_WIPER;
        link2.cmd_pot = '0;
        link2.cmd_slot = '0;
        link2.cmd_data = '0;
        repeat (4) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        tick();
        for (int p = 0; p < 2; p++)
        begin
            do_cmd(OP_READ_WIPER, p[0], 2'h0, 8'h00, rd);
            check(rd, 8'h20); // restored position
            check(taps[p], 64'h1 << 32); // one tap
        end
        do_cmd(OP_WRITE_AMP, 1'h0, 2'h0, 8'ha5, rd);
        do_cmd(OP_READ_AMP, 1'h0, 2'h0, 8'h00, rd);
        check(rd, 8'ha5); // amplifier readback
        check({amp, 2'h0, pos[0]}, {8'ha5, 8'h20}); // wiper untouched
        for (int s = 0; s < 4; s++)
        begin
            do_cmd(OP_WRITE_STORED, 1'h1, s[1:0], 8'h11 + s[7:0], rd); // held off until the previous stored write ends
            do_cmd(OP_READ_BUSY, 1'h0, 2'h0, 8'h00, rd);
            check(rd, 8'h01); // busy while writing
            check(busy, 1'b1); // busy pin set
        end
        for (int n = 0; n < 30 && rd !== 8'h00; n++)
            do_cmd(OP_READ_BUSY, 1'h0, 2'h0, 8'h00, rd);
        check(rd, 8'h00); // busy clears
        check(busy, 1'b0); // busy pin clears
        for (int s = 0; s < 4; s++)
        begin
            do_cmd(OP_READ_STORED, 1'h1, s[1:0], 8'h00, rd);
            check(rd, 8'h11 + s[7:0]); // stored readback
        end
        do_cmd(OP_STORED_TO_WIPER, 1'h1, 2'h2, 8'h00, rd);
        check(pos[1], 6'h13); // stored to wiper
        do_cmd(OP_WIPER_TO_STORED, 1'h1, 2'h0, 8'h00, rd); // power-up slot
        do_cmd(OP_READ_STORED, 1'h1, 2'h0, 8'h00, rd);
        check(rd, 8'h13); // wiper to stored
        do_cmd(OP_WRITE_WIPER, 1'h0, 2'h0, 8'h05, rd);
        do_cmd(OP_GLOBAL_TO_WIPER, 1'h0, 2'h3, 8'h00, rd);
        check({2'h0, pos[0], 2'h0, pos[1]}, {8'h20, 8'h14}); // all wipers loaded
        do_cmd(OP_WRITE_WIPER, 1'h1, 2'h0, 8'h2a, rd);
        do_cmd(OP_GLOBAL_TO_STORED, 1'h0, 2'h1, 8'h00, rd);
        do_cmd(OP_READ_STORED, 1'h1, 2'h1, 8'h00, rd);
        check(rd, 8'h2a); // pot 1 stored written
        do_cmd(OP_WRITE_WIPER, 1'h0, 2'h0, 8'h3e, rd);
        do_step(1'b1);
        check(pos[0], 6'h3f); // step up
        do_step(1'b1);
        check(taps[0], 64'h1 << 63); // saturate top
        do_cmd(OP_WRITE_WIPER, 1'h0, 2'h0, 8'h01, rd);
        do_step(1'b0);
        do_step(1'b0);
        check(taps[0], 64'h1); // saturate bottom
        do_cmd(OP_STEP_WIPER, 1'h1, 2'h0, 8'h00, rd);
        check(pos[1], 6'h29); // instruction step down
        do_cmd(OP_STEP_WIPER, 1'h1, 2'h0, 8'h01, rd);
        check(pos[1], 6'h2a); // instruction step up
        do_cmd(opcode_t'(4'hf), 1'h1, 2'h0, 8'hff, rd); // unknown opcode
        check({rd, 2'h0, pos[1]}, {8'h00, 8'h2a}); // zero answer, wiper kept
        pulse2(1'b1, 1'b1);
        check(pos2[0], 6'h20); // deselected ignored
        pulse2(1'b0, 1'b1);
        check(pos2[0], 6'h21); // pin step up
        pulse2(1'b0, 1'b0);
        check(pos2[0], 6'h20); // pin step down
        rst_i = 1'b1;
        tick();
        rst_i = 1'b0;
        repeat (2) tick();
        check({2'h0, pos[0], 2'h0, pos[1]}, {8'h20, 8'h20}); // restore again
        give_verdict();
    end
endmodule // wiper_position_control_tb
`default_nettype wire
